// File: design/dcbcc_map.vh
// Constants for the DC-breaker and contactor control block.
// Behaviour
// - Breaker close/open command follows the supply-on flag, status word bit 7.
// - Missing supply acknowledge while supply-on is active sets fault word two bit 7.
// - Missing DC-breaker acknowledge sets alarm bit 2, forces 150 degrees, single pulses.
// - Trip condition raises a continuous breaker-trip level on status bit 14.
// - Same trip condition raises a 4 s breaker-trip pulse on status bit 15.
// - Trip sources: regenerating undervoltage, armature overcurrent, fast current rise.
// - Digital outputs carrying a trip signal update at once, not on schedule.
// - In US contactor mode output 8 follows status bit 10, the breaker-on command.
// - Brake contactor on command is reported on status word bit 8.
// - Separate stop method for on/off, run and emergency stop events.
// - Dynamic braking only for events whose stop method selects it.
// - Activating dynamic braking at once sets status bit 6.
// - Brake contactor on only after zero current and breaker acknowledge gone.
`ifndef DCBCC_MAP_VH
`define DCBCC_MAP_VH

`define CLK_KHZ 125000
`define TRIP_PULSE_MS 4000
`define OUT_UPDATE_MS 2

`define ADDR_CTRL 8'h00
`define ADDR_SETTLE 8'h04
`define ADDR_DOSEL 8'h08
`define ADDR_STATUS 8'h0c
`define ADDR_FW1 8'h10
`define ADDR_FW2 8'h14
`define ADDR_FW3 8'h18
`define ADDR_ALARM1 8'h1c
`define ADDR_DOUT 8'h20

`define CTRL_ON 0
`define CTRL_US_MODE 1
`define CTRL_ONOFF_LSB 2
`define CTRL_RUN_LSB 4
`define CTRL_ESTOP_LSB 6
`define CTRL_SUPSRC_LSB 8
`define CTRL_DCBSRC_LSB 12
`define CTRL_FAULT_RST 16
`define CTRL_RST 16'h0000
`define SETTLE_RST 16'h30d4
`define DOSEL_RST 32'h0000_0000

`define ST_BRAKE_ACT 6
`define ST_SUPPLY_ON 7
`define ST_BRAKE_ON 8
`define ST_US_ON 10
`define ST_TRIP_LVL 14
`define ST_TRIP_PLS 15

`define FW1_UNDERVOLT 11
`define FW1_OVERCUR 1
`define FW2_SUPPLY_ACK 7
`define FW3_CUR_RISE 6
`define AW1_DCB_ACK 2

`define STOP_RAMP 2'h0
`define STOP_COAST 2'h1
`define STOP_TORQUE 2'h2
`define STOP_BRAKE 2'h3

`define ALPHA_FORCED 8'h96
`define US_DO_SEL 4'ha

`endif

// File: design/dcbcc_settle.v
// Settling timer that qualifies an acknowledge check after a command change.
module dcbcc_settle (
  input wire clock_i, // System clock.
  input wire arst_n_i, // Asynchronous reset, active low.
  input wire cmd_i, // Close command being checked.
  input wire [15:0] limit_i, // Settling time in clock cycles.
  output wire settled_o // High once the command has stood for the settling time.
);
  reg cmd_ff;
  reg [15:0] cnt_ff;
  reg [15:0] nxt_cnt;

  always @* begin
    nxt_cnt = cnt_ff;
    if (cmd_i != cmd_ff) begin
      nxt_cnt = 16'h0000;
    end else if (cnt_ff < limit_i) begin
      nxt_cnt = cnt_ff + 16'h0001;
    end
  end

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_ff <= 1'b0;
      cnt_ff <= 16'h0000;
    end else begin
      cmd_ff <= cmd_i;
      cnt_ff <= nxt_cnt;
    end
  end

  // A change of command restarts the count, so a check never runs mid-travel.
  assign settled_o = (cmd_i == cmd_ff) && (cnt_ff >= limit_i);
endmodule

// File: design/dcbcc_pulse.v
// Retriggerable fixed-length pulse generator.
module dcbcc_pulse #(
  parameter [31:0] LEN = 32'h0000_0001
) (
  input wire clock_i, // System clock.
  input wire arst_n_i, // Asynchronous reset, active low.
  input wire trig_i, // Start or restart the pulse.
  output wire pulse_o // High for LEN cycles after the trigger.
);
  reg [31:0] cnt_ff;

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff <= 32'h0000_0000;
    end else if (trig_i) begin
      cnt_ff <= LEN;
    end else if (cnt_ff != 32'h0000_0000) begin
      cnt_ff <= cnt_ff - 32'h0000_0001;
    end
  end

  assign pulse_o = (cnt_ff != 32'h0000_0000);
endmodule

// File: design/dcbcc_top.v
// DC-breaker, AC-breaker and DC-contactor control with trip and braking logic.
//
// Design decisions made here: the address map and the address-and-strobe port.
`include "dcbcc_map.vh"

module dcbcc_top #(
  parameter [31:0] TRIP_PULSE_CYC = `TRIP_PULSE_MS * `CLK_KHZ,
  parameter [31:0] OUT_UPDATE_CYC = `OUT_UPDATE_MS * `CLK_KHZ
) (
  input wire clock_i, // System clock, 125 MHz.
  input wire arst_n_i, // Asynchronous reset, active low.
  input wire [7:0] reg_addr_i, // Register byte address.
  input wire [31:0] reg_wdata_i, // Register write data.
  input wire reg_wr_i, // Register write strobe.
  input wire reg_rd_i, // Register read strobe.
  output wire [31:0] reg_rdata_o, // Read data, valid the cycle after the strobe.
  input wire [7:0] di_i, // Digital inputs carrying acknowledge contacts.
  input wire regen_i, // Drive is regenerating.
  input wire undervolt_i, // Mains undervoltage detected.
  input wire overcur_i, // Armature overcurrent detected.
  input wire cur_rise_i, // Excessive current rise rate detected.
  input wire cur_zero_i, // Armature current is zero.
  input wire zero_speed_i, // Zero speed reached.
  input wire onoff_clear_i, // On/off command cleared event.
  input wire run_clear_i, // Run command cleared event.
  input wire estop_i, // Emergency stop event.
  input wire [7:0] firing_angle_i, // Firing angle from the current controller.
  output wire breaker_close_o, // Breaker close command, high closes.
  output wire us_breaker_on_o, // US contactor on command.
  output wire brake_contactor_on_o, // Brake contactor close command.
  output wire trip_level_o, // Continuous breaker trip.
  output wire trip_pulse_o, // Timed breaker trip pulse.
  output wire [7:0] firing_angle_o, // Firing angle to the gate unit.
  output wire single_pulse_o, // Single firing pulses only.
  output wire [1:0] stop_method_o, // Stop method of the latest stop event.
  output wire stop_valid_o, // One-cycle pulse with a new stop method.
  output wire [7:0] dout_o, // Digital outputs.
  output wire [15:0] status_word_o // Current-control status word.
);
  // Software-visible configuration.
  reg [15:0] ctrl_ff;
  reg [15:0] settle_ff;
  reg [31:0] dosel_ff;

  // Sticky fault bits and the latched trip cause.
  reg fw1_uv_ff;
  reg fw1_oc_ff;
  reg fw2_ack_ff;
  reg fw3_rise_ff;
  reg trip_cause_ff;
  reg trip_cause_d_ff;

  // Contactor, braking and firing state.
  reg brake_act_ff;
  reg brake_on_ff;
  reg supply_on_ff;
  reg us_on_ff;
  reg dcb_alarm_ff;
  reg [7:0] alpha_ff;
  reg single_ff;
  reg [1:0] stop_method_ff;
  reg stop_valid_ff;

  // Output refresh and bus read path.
  reg [7:0] dout_ff;
  reg [31:0] tick_cnt_ff;
  reg [31:0] rdata_ff;

  // Combinational values, each assigned on every path.
  reg [15:0] status;
  reg [31:0] nxt_rdata;
  reg [7:0] nxt_dout;
  reg [3:0] sel;
  reg nxt_brake_req;
  reg [1:0] nxt_method;
  integer k;

  wire wr_ctrl = reg_wr_i && (reg_addr_i == `ADDR_CTRL);
  wire fault_reset = wr_ctrl && reg_wdata_i[`CTRL_FAULT_RST];

  wire us_mode = ctrl_ff[`CTRL_US_MODE];
  wire [1:0] onoff_method = ctrl_ff[`CTRL_ONOFF_LSB +: 2];
  wire [1:0] run_method = ctrl_ff[`CTRL_RUN_LSB +: 2];
  wire [1:0] estop_method = ctrl_ff[`CTRL_ESTOP_LSB +: 2];

  wire [3:0] supply_ack_source = ctrl_ff[`CTRL_SUPSRC_LSB +: 4];
  wire [3:0] dcb_ack_input_select = ctrl_ff[`CTRL_DCBSRC_LSB +: 4];

  // The slow output schedule fires each time its down-counter reaches zero.
  wire tick = (tick_cnt_ff == 32'h0000_0000);

  // A source of zero means no acknowledge is wired, so no check is made.
  wire sup_ack_used = (supply_ack_source != 4'h0) && (supply_ack_source <= 4'h8);
  wire dcb_ack_used = (dcb_ack_input_select != 4'h0) && (dcb_ack_input_select <= 4'h8);
  wire sup_ack = sup_ack_used && di_i[supply_ack_source[2:0] - 3'h1];
  wire dcb_ack = dcb_ack_used && di_i[dcb_ack_input_select[2:0] - 3'h1];

  wire trip_event = (undervolt_i && regen_i) || overcur_i || cur_rise_i;

  // Dynamic braking also opens the breaker, so it shares the trip level.
  wire trip_level = trip_cause_ff || brake_act_ff;
  wire dcb_close_cmd = supply_on_ff && !trip_level;

  wire sup_settled;
  wire dcb_settled;
  wire trip_pulse;

  // Supply acknowledge is judged only after the close command has settled.
  dcbcc_settle u_sup_settle (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .cmd_i(supply_on_ff),
    .limit_i(settle_ff),
    .settled_o(sup_settled)
  );

  // The breaker check follows its own command, which a trip withdraws.
  dcbcc_settle u_dcb_settle (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .cmd_i(dcb_close_cmd),
    .limit_i(settle_ff),
    .settled_o(dcb_settled)
  );

  // A missing contact counts only while its check is enabled and settled.
  wire sup_missing = sup_ack_used && supply_on_ff && sup_settled && !sup_ack;
  wire dcb_missing = dcb_ack_used && dcb_close_cmd && dcb_settled && !dcb_ack;

  // The pulse starts on the rising edge of the latched trip cause and then times out.
  // A standing fault therefore gives one pulse, not a train of them.
  dcbcc_pulse #(
    .LEN(TRIP_PULSE_CYC)
  ) u_trip_pulse (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .trig_i(trip_cause_ff && !trip_cause_d_ff),
    .pulse_o(trip_pulse)
  );

  always @* begin
    // Bits not listed here are not driven by this block and read as zero.
    status = 16'h0000;
    status[`ST_BRAKE_ACT] = brake_act_ff;
    status[`ST_SUPPLY_ON] = supply_on_ff;
    status[`ST_BRAKE_ON] = brake_on_ff;
    status[`ST_US_ON] = us_on_ff;
    status[`ST_TRIP_LVL] = trip_level;
    status[`ST_TRIP_PLS] = trip_pulse;
  end

  // Pick the method of the stop event; a later-listed event overrides earlier ones.
  always @* begin
    nxt_brake_req = 1'b0;
    nxt_method = stop_method_ff;
    if (onoff_clear_i) begin
      nxt_method = onoff_method;
      nxt_brake_req = (onoff_method == `STOP_BRAKE);
    end
    if (run_clear_i) begin
      nxt_method = run_method;
      nxt_brake_req = nxt_brake_req || (run_method == `STOP_BRAKE);
    end
    // Emergency stop is listed last, so its method is the one reported.
    if (estop_i) begin
      nxt_method = estop_method;
      nxt_brake_req = nxt_brake_req || (estop_method == `STOP_BRAKE);
    end
  end

  // Outputs refresh on the slow schedule, except trip bits which pass at once.
  // A slow refresh of a trip bit would leave the breaker closed for up to one period.
  always @* begin
    nxt_dout = dout_ff;
    sel = 4'h0;
    for (k = 0; k < 8; k = k + 1) begin
      sel = dosel_ff[k*4 +: 4];
      if ((k == 7) && us_mode) begin
        sel = `US_DO_SEL;
      end
      if (tick) begin
        nxt_dout[k] = status[sel];
      end else if ((sel == 4'd`ST_TRIP_LVL) || (sel == 4'd`ST_TRIP_PLS)) begin
        nxt_dout[k] = status[sel];
      end
    end
  end

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_ff <= `CTRL_RST;
      settle_ff <= `SETTLE_RST;
      dosel_ff <= `DOSEL_RST;
    end else begin
      // Bit 16 of a control write is a reset pulse and is never stored.
      if (wr_ctrl) begin
        ctrl_ff <= reg_wdata_i[15:0];
      end
      if (reg_wr_i && (reg_addr_i == `ADDR_SETTLE)) begin
        settle_ff <= reg_wdata_i[15:0];
      end
      if (reg_wr_i && (reg_addr_i == `ADDR_DOSEL)) begin
        dosel_ff <= reg_wdata_i;
      end
    end
  end

  // Fault and trip latches: a new event in the reset cycle keeps the bit set.
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fw1_uv_ff <= 1'b0;
      fw1_oc_ff <= 1'b0;
      fw2_ack_ff <= 1'b0;
      fw3_rise_ff <= 1'b0;
      trip_cause_ff <= 1'b0;
      trip_cause_d_ff <= 1'b0;
    end else begin
      // Undervoltage counts only while regenerating, when the bridge is exposed.
      fw1_uv_ff <= (undervolt_i && regen_i) || (fw1_uv_ff && !fault_reset);
      fw1_oc_ff <= overcur_i || (fw1_oc_ff && !fault_reset);
      fw3_rise_ff <= cur_rise_i || (fw3_rise_ff && !fault_reset);
      fw2_ack_ff <= sup_missing || (fw2_ack_ff && !fault_reset);
      trip_cause_ff <= trip_event || (trip_cause_ff && !fault_reset);
      trip_cause_d_ff <= trip_cause_ff;
    end
  end

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      supply_on_ff <= 1'b0;
      us_on_ff <= 1'b0;
      brake_act_ff <= 1'b0;
      brake_on_ff <= 1'b0;
      stop_method_ff <= `STOP_RAMP;
      stop_valid_ff <= 1'b0;
    end else begin
      // The supply command lags the control bit by one cycle, like the other outputs.
      supply_on_ff <= ctrl_ff[`CTRL_ON];
      us_on_ff <= us_mode && ctrl_ff[`CTRL_ON] && !trip_level;
      stop_method_ff <= nxt_method;
      stop_valid_ff <= onoff_clear_i || run_clear_i || estop_i;
      if (nxt_brake_req) begin
        brake_act_ff <= 1'b1;
      end else if (zero_speed_i) begin
        brake_act_ff <= 1'b0;
      end
      // The resistor is switched in only once the bridge carries no current.
      if (!brake_act_ff || (zero_speed_i && !nxt_brake_req)) begin
        brake_on_ff <= 1'b0;
      end else if (cur_zero_i && !dcb_ack) begin
        brake_on_ff <= 1'b1;
      end
    end
  end

  // A missing breaker acknowledge clamps firing to the forced angle.
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dcb_alarm_ff <= 1'b0;
      alpha_ff <= `ALPHA_FORCED;
      single_ff <= 1'b0;
    end else begin
      dcb_alarm_ff <= dcb_missing;
      if (dcb_missing) begin
        alpha_ff <= `ALPHA_FORCED;
      end else begin
        alpha_ff <= firing_angle_i;
      end
      single_ff <= dcb_missing;
    end
  end

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_cnt_ff <= 32'h0000_0000;
      dout_ff <= 8'h00;
    end else begin
      if (tick) begin
        tick_cnt_ff <= OUT_UPDATE_CYC - 32'h0000_0001;
      end else begin
        tick_cnt_ff <= tick_cnt_ff - 32'h0000_0001;
      end
      dout_ff <= nxt_dout;
    end
  end

  always @* begin
    // Unmapped addresses and unlisted bits read as zero.
    nxt_rdata = 32'h0000_0000;
    case (reg_addr_i)
      `ADDR_CTRL: begin
        nxt_rdata = {16'h0000, ctrl_ff};
      end
      `ADDR_SETTLE: begin
        nxt_rdata = {16'h0000, settle_ff};
      end
      `ADDR_DOSEL: begin
        nxt_rdata = dosel_ff;
      end
      `ADDR_STATUS: begin
        nxt_rdata = {16'h0000, status};
      end
      `ADDR_FW1: begin
        nxt_rdata[`FW1_UNDERVOLT] = fw1_uv_ff;
        nxt_rdata[`FW1_OVERCUR] = fw1_oc_ff;
      end
      `ADDR_FW2: begin
        nxt_rdata[`FW2_SUPPLY_ACK] = fw2_ack_ff;
      end
      `ADDR_FW3: begin
        nxt_rdata[`FW3_CUR_RISE] = fw3_rise_ff;
      end
      `ADDR_ALARM1: begin
        nxt_rdata[`AW1_DCB_ACK] = dcb_alarm_ff;
      end
      `ADDR_DOUT: begin
        nxt_rdata = {24'h000000, dout_ff};
      end
      default: begin
        nxt_rdata = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      if (reg_rd_i) begin
        rdata_ff <= nxt_rdata;
      end else begin
        rdata_ff <= 32'h0000_0000;
      end
    end
  end

  assign reg_rdata_o = rdata_ff;

  assign breaker_close_o = supply_on_ff;
  assign us_breaker_on_o = us_on_ff;
  assign brake_contactor_on_o = brake_on_ff;
  assign trip_level_o = trip_level;
  assign trip_pulse_o = trip_pulse;
  assign firing_angle_o = alpha_ff;
  assign single_pulse_o = single_ff;
  assign stop_method_o = stop_method_ff;
  assign stop_valid_o = stop_valid_ff;
  assign dout_o = dout_ff;
  assign status_word_o = status;
endmodule

// File: tb/dcbcc_asserts.sv
// Port-level checker for the breaker and contactor control block.
module dcbcc_asserts #(
  parameter [31:0] TRIP_PULSE_CYC = 32'h0000_0014
) (
  input logic clock_i, // Clock.
  input logic arst_n_i, // Reset, active low.
  input logic [7:0] reg_addr_i, // Address.
  input logic [31:0] reg_wdata_i, // Write data.
  input logic reg_wr_i, // Write strobe.
  input logic regen_i, // Regenerating.
  input logic undervolt_i, // Undervoltage.
  input logic overcur_i, // Overcurrent.
  input logic cur_rise_i, // Current rise.
  input logic cur_zero_i, // Zero current.
  input logic onoff_clear_i, // Stop event.
  input logic run_clear_i, // Stop event.
  input logic estop_i, // Stop event.
  input logic [7:0] firing_angle_i, // Angle in.
  input logic breaker_close_o, // Close.
  input logic us_breaker_on_o, // US on.
  input logic brake_contactor_on_o, // Brake on.
  input logic trip_level_o, // Trip level.
  input logic trip_pulse_o, // Trip pulse.
  input logic [7:0] firing_angle_o, // Angle out.
  input logic single_pulse_o, // Single pulses.
  input logic [1:0] stop_method_o, // Method.
  input logic stop_valid_o, // Method valid.
  input logic [15:0] status_word_o // Status.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] cnt_ff;
  logic up_ff;
  wire clr = reg_wr_i && reg_addr_i == 8'h00 && reg_wdata_i[16];
  // Counts high cycles of the trip pulse; a retrigger may only lengthen it.
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff <= 32'h0;
      up_ff <= 1'b0;
    end else begin
      cnt_ff <= trip_pulse_o ? cnt_ff + 32'h1 : 32'h0;
      up_ff <= 1'b1;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_fault;
    overcur_i || cur_rise_i || (undervolt_i && regen_i);
  endsequence
  sequence s_brake_req;
    stop_valid_o && stop_method_o == 2'h3;
  endsequence
  close_follow_a: assert property (breaker_close_o == status_word_o[7])
    else $error("Breaker close differs from status bit 7.");
  trip_set_a: assert property (s_fault |=> trip_level_o && status_word_o[14])
    else $error("Trip level missing after a fault.");
  pulse_start_a: assert property (s_fault ##0 !trip_level_o |-> ##2 trip_pulse_o && status_word_o[15])
    else $error("Trip pulse did not start two cycles after a fault.");
  pulse_len_a: assert property ($fell(trip_pulse_o) |-> cnt_ff >= TRIP_PULSE_CYC)
    else $error("Trip pulse ended too early.");
  level_hold_a: assert property (trip_level_o && !status_word_o[6] && !clr |=> trip_level_o)
    else $error("Trip level dropped without a fault reset.");
  angle_force_a: assert property (single_pulse_o |-> firing_angle_o == 8'h96)
    else $error("Firing angle not forced while single pulses.");
  angle_pass_a: assert property (up_ff && !single_pulse_o |-> firing_angle_o == $past(firing_angle_i))
    else $error("Firing angle not passed through.");
  us_off_a: assert property (trip_level_o |=> !us_breaker_on_o && !status_word_o[10])
    else $error("US breaker on during trip.");
  brake_act_a: assert property (s_brake_req |-> status_word_o[6])
    else $error("Braking not active after a braking stop.");
  brake_src_a: assert property ($rose(status_word_o[6]) |-> stop_valid_o)
    else $error("Braking started without a stop event.");
  brake_on_a: assert property ($rose(brake_contactor_on_o) |-> status_word_o[6] && status_word_o[8] && $past(cur_zero_i))
    else $error("Brake contactor closed out of sequence.");
  stop_ack_a: assert property (onoff_clear_i || run_clear_i || estop_i |=> stop_valid_o)
    else $error("Stop event gave no stop method.");
endmodule

bind dcbcc_top dcbcc_asserts #(.TRIP_PULSE_CYC(TRIP_PULSE_CYC)) u_chk (
  .clock_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .regen_i, .undervolt_i,
  .overcur_i, .cur_rise_i, .cur_zero_i, .onoff_clear_i, .run_clear_i, .estop_i,
  .firing_angle_i, .breaker_close_o, .us_breaker_on_o, .brake_contactor_on_o,
  .trip_level_o, .trip_pulse_o, .firing_angle_o, .single_pulse_o, .stop_method_o,
  .stop_valid_o, .status_word_o
);

// File: tb/dcbcc_far.sv
// Breaker or contactor model with a coil delay and an auxiliary contact.
module dcbcc_far #(
  parameter int DLY = 2
) (
  input logic clock_i, // Clock.
  input logic close_i, // Coil command, high closes.
  input logic fail_i, // Contact stuck open when high.
  output logic ack_o // Auxiliary acknowledge contact.
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_ff = 0;
  // The contact lags the coil, so a check made without settling would misfire.
  always @(posedge clock_i) begin
    cnt_ff <= !close_i ? 0 : (cnt_ff < DLY ? cnt_ff + 1 : cnt_ff);
  end
  assign ack_o = close_i && cnt_ff == DLY && !fail_i;
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the breaker and contactor control block.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] PLS = 32'h14;
  localparam logic [31:0] C = 32'h0000_2101;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [6:0] ev = 7'h0;
  logic regen_i = 1'b0;
  logic cur_zero_i = 1'b0;
  logic [7:0] angle = 8'h21;
  logic fail_s = 1'b0;
  logic fail_d = 1'b0;
  logic [7:0] fa [4] = '{8'h10, 8'h18, 8'h10, 8'h10};
  logic [31:0] fv [4] = '{32'h2, 32'h40, 32'h800, 32'h0};
  wire [31:0] rdata;
  wire [15:0] st;
  wire [7:0] dout;
  wire [7:0] ang_o;
  wire [1:0] meth;
  wire close, us_on, brk_on, trip, tpls, single, svld, ack_s, ack_d;
  int num_errors = 0;
  int cmp_count = 0;
  int i, n, m;
  always #4 clock_i = ~clock_i;
  dcbcc_top #(.TRIP_PULSE_CYC(PLS), .OUT_UPDATE_CYC(32'h8)) dut (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(rdata), .di_i({6'h00, ack_d, ack_s}), .regen_i(regen_i),
    .undervolt_i(ev[2]), .overcur_i(ev[0]), .cur_rise_i(ev[1]), .cur_zero_i(cur_zero_i),
    .zero_speed_i(ev[6]), .onoff_clear_i(ev[3]), .run_clear_i(ev[4]), .estop_i(ev[5]),
    .firing_angle_i(angle), .breaker_close_o(close), .us_breaker_on_o(us_on),
    .brake_contactor_on_o(brk_on), .trip_level_o(trip), .trip_pulse_o(tpls),
    .firing_angle_o(ang_o), .single_pulse_o(single), .stop_method_o(meth),
    .stop_valid_o(svld), .dout_o(dout), .status_word_o(st)
  );
  dcbcc_far #(.DLY(1)) u_sup (.clock_i(clock_i), .close_i(close), .fail_i(fail_s),
    .ack_o(ack_s));
  dcbcc_far #(.DLY(3)) u_dcb (.clock_i(clock_i), .close_i(close & ~trip), .fail_i(fail_d),
    .ack_o(ack_d));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      num_errors++;
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(nm, e, rdata);
  endtask
  task pls(input logic [6:0] k);
    @(posedge clock_i);
    ev <= k;
    @(posedge clock_i);
    ev <= 7'h0;
    #1;
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock_i);
    arst_n_i <= 1'b1;
    rd(8'h00, 32'h0, "control");
    rd(8'h04, 32'h30d4, "settle");
    rd(8'h08, 32'h0, "output select");
    rd(8'h24, 32'h0, "unmapped");
    wr(8'h04, 32'h4);
    wr(8'h08, 32'hfe);
    wr(8'h00, C);
    cyc(12);
    chk("close", 1, close);
    chk("status bit 7", 1, st[7]);
    rd(8'h14, 32'h0, "fault word two");
    rd(8'h1c, 32'h0, "alarm word");
    fail_s <= 1'b1;
    cyc(8);
    rd(8'h14, 32'h80, "fault word two");
    fail_s <= 1'b0;
    fail_d <= 1'b1;
    cyc(8);
    rd(8'h1c, 32'h4, "alarm word");
    chk("single pulses", 1, single);
    chk("forced angle", 8'h96, ang_o);
    fail_d <= 1'b0;
    angle <= 8'h5a;
    cyc(8);
    chk("passed angle", 8'h5a, ang_o);
    wr(8'h00, C | 32'h0001_0000);
    rd(8'h14, 32'h0, "fault word two");
    $display("test acknowledge done");
    for (i = 0; i < 4; i++) begin
      regen_i <= (i == 2);
      pls(7'h1 << ((i == 3) ? 2 : i));
      chk("trip level", i < 3, trip);
      n = 0;
      for (m = 0; m < 40; m++) begin
        cyc(1);
        if (m == 0) chk("trip output", i < 3, dout[0]);
        if (tpls === 1'b1) n++;
      end
      chk("pulse length", (i < 3) ? PLS : 32'h0, n);
      chk("level held", i < 3, trip);
      rd(fa[i], fv[i], "fault word");
      wr(8'h00, C | 32'h0001_0000);
      cyc(2);
      chk("level cleared", 0, trip);
    end
    $display("test trip done");
    wr(8'h00, C | 32'h2);
    cyc(12);
    chk("us on", 1, us_on);
    chk("status bit 10", 1, st[10]);
    chk("output 8", 1, dout[7]);
    wr(8'h00, C);
    $display("test us contactor done");
    for (m = 0; m < 4; m++) begin
      wr(8'h00, C | ((m < 3) ? ((m << 2) | (m << 4) | (m << 6)) : 32'hc0));
      pls(7'h8 << ((m == 3) ? 2 : m));
      chk("stop valid", 1, svld);
      chk("stop method", m, meth);
      chk("braking active", m == 3, st[6]);
    end
    cyc(4);
    chk("brake before zero current", 0, brk_on);
    cur_zero_i <= 1'b1;
    for (i = 0; i < 20 && brk_on !== 1'b1; i++) cyc(1);
    if (i == 20) begin
      $display("CHECK FAILED brake contactor wait expected 1 seen 0");
      num_errors++;
    end
    chk("status bit 8", 1, st[8]);
    pls(7'h40);
    cyc(1);
    chk("braking ended", 0, {st[8], st[6]});
    cur_zero_i <= 1'b0;
    $display("test braking done");
    conclude;
  end
endmodule
